// File: reset_state_initializer.sv
// Reset-state initializer: program counter, core flags and reset cause per event
`timescale 1ns/100ps
`include "reset_init_consts.svh"
module reset_state_initializer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic por_req,
  input wire logic brownout_req,
  input wire logic master_clear_pin,
  input wire logic sleeping,
  input wire logic watchdog_timer_expire,
  input wire logic irq_wake_req,
  input wire logic [7:0] irq_source_flags,
  input wire logic global_irq_enable,
  input wire logic instr_done,
  input wire logic [12:0] core_pc,
  output logic [12:0] pc_value,
  output logic pc_load,
  output reset_init_pkg::core_flags_type core_flags,
  output logic [1:0] reset_cause_reg,
  output logic irq
);
  import reset_init_pkg::*;

  logic [1:0] rst_pipe;
  logic rst_sync;
  top_state_type state;
  top_state_type next_state;
  logic [6:0] irq_status;
  logic [6:0] irq_mask;
  logic apb_write;
  logic apb_setup;
  reg_sel_type wsel;
  reg_sel_type rsel;
  event_link_if ev ();

  // ========================================
  // Address decode shared by read, write and error paths
  function automatic reg_sel_type reg_decode(input logic [11:0] addr);
    if (addr == `REG_ADDR(`CAUSE_INDEX)) begin
      return SEL_CAUSE;
    end else if (addr == `REG_ADDR(`FLAGS_INDEX)) begin
      return SEL_FLAGS;
    end else if (addr == `REG_ADDR(`IRQ_STAT_INDEX)) begin
      return SEL_ISTAT;
    end else if (addr == `REG_ADDR(`IRQ_MASK_INDEX)) begin
      return SEL_IMASK;
    end else begin
      return SEL_NONE;
    end
  endfunction

  // ========================================
  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync = rst_pipe[1];

  // ========================================
  // Sub-blocks
  event_encoder u_encoder (
    .clk(core_clk),
    .rst_n(rst_sync),
    .por_req(por_req),
    .brownout_req(brownout_req),
    .master_clear_pin(master_clear_pin),
    .sleeping(sleeping),
    .watchdog_timer_expire(watchdog_timer_expire),
    .irq_wake_req(irq_wake_req),
    .irq_source_flags(irq_source_flags),
    .ev(ev.src)
  );

  event_irq_bank u_irq (
    .clk(core_clk),
    .rst_n(rst_sync),
    .ev(ev.sink),
    .wr_status(apb_write && (wsel == SEL_ISTAT)),
    .wr_mask(apb_write && (wsel == SEL_IMASK)),
    .wdata(pwdata[6:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ========================================
  // APB strobes; zero wait states
  assign apb_write = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign wsel = reg_decode(paddr);
  assign rsel = reg_decode(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && (wsel == SEL_NONE);

  // ========================================
  // Next state: software writes first, hardware events override
  always_comb begin
    next_state = state;
    next_state.pc_load = 1'b0;
    // Register writes
    if (apb_write && (wsel == SEL_CAUSE)) begin
      next_state.cause = pwdata[1:0];
    end
    if (apb_write && (wsel == SEL_FLAGS)) begin
      next_state.flags = core_flags_type'((pwdata[7:0] & `FLAG_SW_MASK) |
                                          (state.flags & ~`FLAG_SW_MASK));
    end
    // Vector jump after the instruction following the wake
    if ((state.seq == SEQ_WAIT_INSTR) && instr_done) begin
      next_state.pc = `PC_VECTOR;
      next_state.pc_load = 1'b1;
      next_state.seq = SEQ_IDLE;
    end
    // Reset and wake events
    if (ev.valid) begin
      next_state.seq = SEQ_IDLE;
      case (ev.kind)
        EV_POWER_ON: begin
          next_state.pc = `PC_RESET;
          next_state.pc_load = 1'b1;
          next_state.flags = core_flags_type'(`FLAGS_POWER_ON);
          next_state.cause[`CAUSE_POWERON] = 1'b0;
        end
        EV_BROWN_OUT: begin
          next_state.pc = `PC_RESET;
          next_state.pc_load = 1'b1;
          next_state.flags = core_flags_type'(`FLAGS_POWER_ON);
          next_state.cause = `CAUSE_BROWNOUT_VALUE;
        end
        EV_CLEAR_RUN: begin
          next_state.pc = `PC_RESET;
          next_state.pc_load = 1'b1;
          next_state.flags.indirect_bank_select = 1'b0;
          next_state.flags.bank_hi = 1'b0;
          next_state.flags.bank_lo = 1'b0;
        end
        EV_CLEAR_SLEEP: begin
          next_state.pc = `PC_RESET;
          next_state.pc_load = 1'b1;
          next_state.flags.indirect_bank_select = 1'b0;
          next_state.flags.bank_hi = 1'b0;
          next_state.flags.bank_lo = 1'b0;
          next_state.flags.timeout = 1'b1;
          next_state.flags.powerdown = 1'b0;
        end
        EV_DOG_RESET: begin
          next_state.pc = `PC_RESET;
          next_state.pc_load = 1'b1;
          next_state.flags.indirect_bank_select = 1'b0;
          next_state.flags.bank_hi = 1'b0;
          next_state.flags.bank_lo = 1'b0;
          next_state.flags.timeout = 1'b0;
        end
        EV_DOG_WAKE: begin
          next_state.pc = 13'(core_pc + 13'h0001);
          next_state.pc_load = 1'b1;
          next_state.flags.timeout = 1'b0;
          next_state.flags.powerdown = 1'b0;
        end
        EV_IRQ_WAKE: begin
          next_state.pc = 13'(core_pc + 13'h0001);
          next_state.pc_load = 1'b1;
          next_state.flags.timeout = 1'b1;
          next_state.flags.powerdown = 1'b0;
          if (global_irq_enable) begin
            next_state.seq = SEQ_WAIT_INSTR;
          end
        end
        default: begin
          next_state.seq = state.seq;
        end
      endcase
    end
    // Read data captured in the setup phase; upper bits zero
    if (apb_setup && !pwrite) begin
      case (rsel)
        SEL_CAUSE: next_state.prdata = {30'h0, state.cause};
        SEL_FLAGS: next_state.prdata = {24'h0, state.flags};
        SEL_ISTAT: next_state.prdata = {25'h0, irq_status};
        SEL_IMASK: next_state.prdata = {25'h0, irq_mask};
        default: next_state.prdata = 32'h0;
      endcase
    end
  end

  // State register; power-on values at reset
  always_ff @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= '{cause: `CAUSE_RESET, flags: core_flags_type'(`FLAGS_POWER_ON),
                 pc: `PC_RESET, pc_load: 1'b0, seq: SEQ_IDLE, prdata: 32'h0};
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.prdata;
  assign pc_value = state.pc;
  assign pc_load = state.pc_load;
  assign core_flags = state.flags;
  assign reset_cause_reg = state.cause;

  // ========================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync);

  sequence s_wake_enabled;
    ev.valid && (ev.kind == EV_IRQ_WAKE) && global_irq_enable;
  endsequence

  sequence s_vector_jump;
    (state.seq == SEQ_WAIT_INSTR) ##1 instr_done && !ev.valid ##1
      pc_load && (pc_value == `PC_VECTOR);
  endsequence

  chk_clear_run_pc: assert property (ev.valid && (ev.kind == EV_CLEAR_RUN) |=>
    pc_load && (pc_value == `PC_RESET) && (core_flags[7:5] == 3'h0) &&
    (core_flags[4:3] == $past(core_flags[4:3])))
    else $error("clear-pin run reset wrong");

  chk_clear_sleep_flags: assert property (ev.valid && (ev.kind == EV_CLEAR_SLEEP) |=>
    (pc_value == `PC_RESET) && (core_flags[7:3] == 5'h02) &&
    (core_flags[2:0] == $past(core_flags[2:0])))
    else $error("clear-pin sleep reset wrong");

  chk_brownout_cause: assert property (ev.valid && (ev.kind == EV_BROWN_OUT) |=>
    reset_cause_reg == 2'h2)
    else $error("brown-out cause wrong");

  chk_dog_reset: assert property (ev.valid && (ev.kind == EV_DOG_RESET) |=>
    (pc_value == `PC_RESET) && (core_flags[7:4] == 4'h0) &&
    (reset_cause_reg == $past(reset_cause_reg)))
    else $error("watchdog reset wrong");

  chk_wake_arm: assert property (s_wake_enabled |=> pc_load &&
    (pc_value == $past(core_pc) + 13'h0001) && (state.seq == SEQ_WAIT_INSTR))
    else $error("interrupt wake not armed");

  chk_vector_load: assert property ((state.seq == SEQ_WAIT_INSTR) && instr_done &&
    !ev.valid |=> pc_load && (pc_value == `PC_VECTOR) && (state.seq == SEQ_IDLE))
    else $error("vector not loaded");

  chk_vector_order: cover property (s_wake_enabled ##1 s_vector_jump);

  chk_wake_source: assert property (ev.valid && (ev.kind == EV_IRQ_WAKE) |->
    $past(|irq_source_flags) && $past(sleeping))
    else $error("wake without source flag");

  chk_wake_flags: assert property (ev.valid && ((ev.kind == EV_IRQ_WAKE) ||
    (ev.kind == EV_DOG_WAKE)) |=> !core_flags.powerdown &&
    (core_flags.timeout == ($past(ev.kind) == EV_IRQ_WAKE)) &&
    (core_flags[7:5] == $past(core_flags[7:5])) && (reset_cause_reg == $past(reset_cause_reg)))
    else $error("wake flags wrong");

  chk_unimpl_zero: assert property (apb_setup && !pwrite && (rsel == SEL_CAUSE) |=>
    prdata[31:2] == 30'h0)
    else $error("unimplemented cause bits nonzero");

  chk_power_on: assert property (ev.valid && (ev.kind == EV_POWER_ON) |=>
    (pc_value == `PC_RESET) && (core_flags[7:3] == 5'h03) && !reset_cause_reg[1] &&
    (reset_cause_reg[0] == $past(reset_cause_reg[0])))
    else $error("power-on state wrong");

  chk_cause_write: assert property (apb_write && (wsel == SEL_CAUSE) && !ev.valid |=>
    reset_cause_reg == $past(pwdata[1:0]))
    else $error("cause write lost");

  chk_cause_hold: assert property (!ev.valid && !(apb_write && (wsel == SEL_CAUSE)) |=>
    $stable(reset_cause_reg))
    else $error("cause changed without cause");

  // ========================================
  // Further checks on loads, reads and cause flags

  // A wake with the enable set holds back the vector until the next instruction ends
  sequence s_waiting_quiet;
    (state.seq == SEQ_WAIT_INSTR) && !instr_done && !ev.valid;
  endsequence

  chk_no_early_vector: assert property (s_waiting_quiet |=> !pc_load &&
    (state.seq == SEQ_WAIT_INSTR))
    else $error("vector loaded before the instruction ended");

  // A load pulse comes only from an event or from the vector jump
  chk_load_source: assert property (pc_load |-> $past(ev.valid) ||
    $past((state.seq == SEQ_WAIT_INSTR) && instr_done))
    else $error("program counter load without a cause");

  // Brown-out loads the same program counter and flags as a power-on
  chk_brownout_state: assert property (ev.valid && (ev.kind == EV_BROWN_OUT) |=>
    pc_load && (pc_value == `PC_RESET) && (core_flags[7:3] == 5'h03))
    else $error("brown-out state wrong");

  // Clear-pin resets keep both cause flags
  chk_clear_cause_keep: assert property (ev.valid && ((ev.kind == EV_CLEAR_RUN) ||
    (ev.kind == EV_CLEAR_SLEEP)) && !(apb_write && (wsel == SEL_CAUSE)) |=>
    reset_cause_reg == $past(reset_cause_reg))
    else $error("clear-pin reset changed the cause");

  // Reads show the fields and zero in every bit above them
  chk_flags_read: assert property (apb_setup && !pwrite && (rsel == SEL_FLAGS) |=>
    prdata == {24'h0, $past(core_flags)})
    else $error("flags read wrong");

  chk_irq_read_zero: assert property (apb_setup && !pwrite &&
    ((rsel == SEL_ISTAT) || (rsel == SEL_IMASK)) |=> prdata[31:7] == 25'h0)
    else $error("interrupt register bits above the field nonzero");

  chk_unmapped_read: assert property (apb_setup && !pwrite && (rsel == SEL_NONE) |=>
    prdata == 32'h0)
    else $error("unmapped read nonzero");

  // A watchdog wake resumes after the sleep instruction
  chk_dog_wake_pc: assert property (ev.valid && (ev.kind == EV_DOG_WAKE) |=> pc_load &&
    (pc_value == $past(core_pc) + 13'h0001))
    else $error("watchdog wake address wrong");

  // An interrupt request while awake raises no event
  chk_wake_ignored: assert property (irq_wake_req && !sleeping && !por_req &&
    !brownout_req && !master_clear_pin && !watchdog_timer_expire |=> !ev.valid)
    else $error("wake taken while awake");
endmodule

// File: reset_init_consts.svh
// Offsets, field positions, reset values and codes of the reset-state initializer
`ifndef RESET_INIT_CONSTS_SVH
`define RESET_INIT_CONSTS_SVH

// ========================================
// Register indices; byte address is four times the index
`define CAUSE_INDEX 8'h8e
`define FLAGS_INDEX 8'h03
`define IRQ_STAT_INDEX 8'h40
`define IRQ_MASK_INDEX 8'h41
`define REG_ADDR(idx) ({2'b00, (idx), 2'b00})

// ========================================
// Core flag fields
`define FLAG_INDIRECT_BANK 7
`define FLAG_BANK_HI 6
`define FLAG_BANK_LO 5
`define FLAG_TIMEOUT 4
`define FLAG_POWERDOWN 3
`define FLAG_SW_MASK 8'he7

// ========================================
// Reset-cause fields
`define CAUSE_POWERON 1
`define CAUSE_BROWNOUT 0
`define CAUSE_WIDTH 2

// ========================================
// Reset values and vectors
`define CAUSE_RESET 2'h0
`define CAUSE_BROWNOUT_VALUE 2'h2
`define FLAGS_POWER_ON 8'h18
`define PC_RESET 13'h0000
`define PC_VECTOR 13'h0004
`define NUM_EVENTS 7

`endif

// File: reset_init_pkg.sv
// Types shared by the reset-state initializer modules
package reset_init_pkg;

  // Reset and wake-up conditions, in falling priority
  typedef enum logic [2:0] {
    EV_NONE, EV_POWER_ON, EV_BROWN_OUT, EV_CLEAR_RUN, EV_CLEAR_SLEEP,
    EV_DOG_RESET, EV_DOG_WAKE, EV_IRQ_WAKE
  } event_kind_type;

  typedef enum {SEQ_IDLE, SEQ_WAIT_INSTR} seq_type;

  typedef enum {SEL_NONE, SEL_CAUSE, SEL_FLAGS, SEL_ISTAT, SEL_IMASK} reg_sel_type;

  typedef struct packed {
    logic indirect_bank_select;
    logic bank_hi;
    logic bank_lo;
    logic timeout;
    logic powerdown;
    logic zero;
    logic digit_carry;
    logic carry;
  } core_flags_type;

  typedef struct packed {
    logic [1:0] cause;
    core_flags_type flags;
    logic [12:0] pc;
    logic pc_load;
    seq_type seq;
    logic [31:0] prdata;
  } top_state_type;

  typedef struct packed {
    logic valid;
    event_kind_type kind;
  } enc_state_type;

  typedef struct packed {
    logic [6:0] status;
    logic [6:0] mask;
  } irq_state_type;

endpackage

// File: event_link_if.sv
// Event strobe and kind passed from the encoder to its consumers
`timescale 1ns/100ps
interface event_link_if;
  import reset_init_pkg::*;
  logic valid;
  event_kind_type kind;
  modport src(output valid, output kind);
  modport sink(input valid, input kind);
endinterface

// File: event_encoder.sv
// Prioritises raw reset and wake-up requests into one event kind
`timescale 1ns/100ps
module event_encoder
  import reset_init_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_req,
  input wire logic brownout_req,
  input wire logic master_clear_pin,
  input wire logic sleeping,
  input wire logic watchdog_timer_expire,
  input wire logic irq_wake_req,
  input wire logic [7:0] irq_source_flags,
  event_link_if.src ev
);
  enc_state_type state;
  enc_state_type next_state;

  // ========================================
  // Priority choice of the event
  always_comb begin
    next_state = '{valid: 1'b1, kind: EV_NONE};
    if (por_req) begin
      next_state.kind = EV_POWER_ON;
    end else if (brownout_req) begin
      next_state.kind = EV_BROWN_OUT;
    end else if (master_clear_pin) begin
      next_state.kind = sleeping ? EV_CLEAR_SLEEP : EV_CLEAR_RUN;
    end else if (watchdog_timer_expire) begin
      next_state.kind = sleeping ? EV_DOG_WAKE : EV_DOG_RESET;
    end else if (irq_wake_req && sleeping && (|irq_source_flags)) begin
      next_state.kind = EV_IRQ_WAKE; // Wake only with a source flag set
    end else begin
      next_state.valid = 1'b0;
    end
  end

  // Register the event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{valid: 1'b0, kind: EV_NONE};
    end else begin
      state <= next_state;
    end
  end

  assign ev.valid = state.valid;
  assign ev.kind = state.kind;
endmodule

// File: event_irq_bank.sv
// Sticky event status bits, mask and level interrupt
`timescale 1ns/100ps
`include "reset_init_consts.svh"
module event_irq_bank
  import reset_init_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  event_link_if.sink ev,
  input wire logic wr_status,
  input wire logic wr_mask,
  input wire logic [6:0] wdata,
  output logic [6:0] status,
  output logic [6:0] mask,
  output logic irq
);
  irq_state_type state;
  irq_state_type next_state;
  logic [6:0] hit;

  // ========================================
  // One event line per status bit
  genvar i;
  generate
    for (i = 0; i < `NUM_EVENTS; i++) begin : g_hit
      assign hit[i] = ev.valid && (ev.kind == event_kind_type'(3'(i + 1)));
    end
  endgenerate

  // Write one to clear; a new event wins over the clear
  always_comb begin
    next_state = state;
    if (wr_status) begin
      next_state.status = state.status & ~wdata;
    end
    if (wr_mask) begin
      next_state.mask = wdata;
    end
    next_state.status = next_state.status | hit;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign status = state.status;
  assign mask = state.mask;
  assign irq = |(state.status & state.mask);
endmodule

// File: test_reset_state_initializer.sv
// Self-checking testbench of the reset-state initializer
`timescale 1ns/100ps
`include "reset_init_consts.svh"
module test_reset_state_initializer;
  import reset_init_pkg::*;

  // ========================================
  // Notes of expected results
  typedef struct packed {logic [12:0] pc; logic [7:0] f; logic [1:0] c;} event_note_type;
  typedef struct packed {logic [31:0] d; logic e; logic q;} read_note_type;

  localparam logic [11:0] a_cause = `REG_ADDR(`CAUSE_INDEX);
  localparam logic [11:0] a_flags = `REG_ADDR(`FLAGS_INDEX);
  localparam logic [11:0] a_stat = `REG_ADDR(`IRQ_STAT_INDEX);
  localparam logic [11:0] a_mask = `REG_ADDR(`IRQ_MASK_INDEX);

  // ========================================
  // Design signals; every input given a value at time zero, outputs left to the design
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [4:0] req = 5'h00;
  logic sleeping = 1'b0;
  logic [7:0] irq_source_flags = 8'h00;
  logic global_irq_enable = 1'b0;
  logic instr_done = 1'b0;
  logic [12:0] core_pc = 13'h0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [12:0] pc_value;
  logic pc_load;
  core_flags_type core_flags;
  logic [1:0] reset_cause_reg;
  logic irq;

  // ========================================
  // Bench state and models
  int miscompares = 0;
  int check_count = 0;
  event_note_type evq[$];
  read_note_type rdq[$];
  event_note_type en;
  read_note_type rn;
  logic [15:0] rnd = 16'h0042;
  logic [7:0] fl = `FLAGS_POWER_ON;
  logic [1:0] cs = `CAUSE_RESET;
  logic [6:0] stat = 7'h00;
  logic [6:0] msk = 7'h00;

  reset_state_initializer i_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .por_req(req[0]),
    .brownout_req(req[1]),
    .master_clear_pin(req[2]),
    .sleeping(sleeping),
    .watchdog_timer_expire(req[3]),
    .irq_wake_req(req[4]),
    .irq_source_flags(irq_source_flags),
    .global_irq_enable(global_irq_enable),
    .instr_done(instr_done),
    .core_pc(core_pc),
    .pc_value(pc_value),
    .pc_load(pc_load),
    .core_flags(core_flags),
    .reset_cause_reg(reset_cause_reg),
    .irq(irq)
  );

  // Clock of 4 ns period
  always #2 core_clk = ~core_clk;

  // ========================================
  // Helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One APB transfer: setup, access until pready, then release
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 50) begin
      miscompares++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
    rdq.push_back('{d, e, |(stat & msk)});
    apb(a, 1'b0, 32'h0000_0000);
  endtask

  // One event request held for a single sampling edge, with its expected effect
  task automatic ev(input int k, input logic irq_en);
    logic [4:0] r;
    logic [12:0] pcx;
    logic push;
    rnd = lfsr_next(rnd);
    push = (k <= 7);
    pcx = (k == 6 || k == 7) ? rnd[15:3] + 13'h0001 : `PC_RESET;
    case (k)
      1: begin
        r = 5'b00011; // Power-on together with brown-out: power-on wins
        fl = `FLAGS_POWER_ON;
        cs[1] = 1'b0;
      end
      2: begin
        r = 5'b00010;
        fl = `FLAGS_POWER_ON;
        cs = `CAUSE_BROWNOUT_VALUE;
      end
      3, 4: begin
        r = 5'b00100;
        fl[7:5] = 3'h0;
        if (k == 4) fl[4:3] = 2'b10;
      end
      5: begin
        r = 5'b01000;
        fl[7:4] = 4'h0;
      end
      6: begin
        r = 5'b01000;
        fl[4:3] = 2'b00;
      end
      default: begin
        r = 5'b10000;
        if (k == 7) fl[4:3] = 2'b10;
      end
    endcase
    if (push) begin
      stat[k-1] = 1'b1;
      evq.push_back('{pcx, fl, cs});
    end
    @(posedge core_clk);
    req <= r;
    sleeping <= (k == 4 || k == 6 || k == 7 || k == 8);
    irq_source_flags <= (k == 8) ? 8'h00 : (rnd[7:0] | 8'h01);
    core_pc <= rnd[15:3];
    global_irq_enable <= irq_en;
    @(posedge core_clk);
    req <= 5'h00;
    repeat (5) @(posedge core_clk);
    if (k == 7) begin
      if (irq_en) evq.push_back('{`PC_VECTOR, fl, cs});
      instr_done <= 1'b1;
      @(posedge core_clk);
      instr_done <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask

  // ========================================
  // Output watcher: each result takes the oldest note of its kind
  always @(negedge core_clk) begin
    if (pc_load === 1'b1) begin
      if (evq.size() == 0) begin
        check("unexpected pc_load", 32'h1, 32'h0);
      end else begin
        en = evq.pop_front();
        check("pc_value", {19'h0, pc_value}, {19'h0, en.pc});
        check("core_flags", {24'h0, core_flags}, {24'h0, en.f});
        check("reset_cause", {30'h0, reset_cause_reg}, {30'h0, en.c});
      end
    end
    if (psel && penable && !pwrite && rdq.size() > 0) begin
      rn = rdq.pop_front();
      check("pready", {31'h0, pready}, 32'h1);
      check("prdata", prdata, rn.d);
      check("pslverr", {31'h0, pslverr}, {31'h0, rn.e});
      check("irq", {31'h0, irq}, {31'h0, rn.q});
    end
  end

  // Hang guard, far beyond the some 160 cycles of the sequence
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end

  // ========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(a_cause, 32'h0, 1'b0);
    rd(a_flags, {24'h0, fl}, 1'b0);
    rd(a_stat, 32'h0, 1'b0);
    rd(a_mask, 32'h0, 1'b0);
    rd(12'h200, 32'h0, 1'b1);
    rnd = lfsr_next(rnd);
    wr(a_flags, {16'h0, rnd});
    fl = (rnd[7:0] & `FLAG_SW_MASK) | (fl & ~`FLAG_SW_MASK);
    rd(a_flags, {24'h0, fl}, 1'b0);
    wr(a_cause, 32'hffff_ffff);
    cs = 2'b11;
    rd(a_cause, 32'h3, 1'b0);
    wr(a_mask, 32'h0000_007f);
    msk = 7'h7f;
    ev(3, 1'b0);
    ev(4, 1'b0);
    ev(5, 1'b0);
    wr(a_flags, 32'h0000_00ff);
    fl = 8'he7 | (fl & 8'h18);
    ev(6, 1'b0);
    ev(7, 1'b1);
    ev(7, 1'b0);
    ev(8, 1'b1);
    ev(9, 1'b1);
    ev(1, 1'b0);
    wr(a_cause, 32'h0000_0003);
    cs = 2'b11;
    ev(2, 1'b0);
    rd(a_cause, {30'h0, cs}, 1'b0);
    rd(a_flags, {24'h0, fl}, 1'b0);
    rd(a_stat, {25'h0, stat}, 1'b0);
    wr(a_mask, 32'h0000_0000);
    msk = 7'h00;
    rd(a_stat, {25'h0, stat}, 1'b0);
    wr(a_stat, 32'h0000_0055);
    stat = stat & ~7'h55;
    wr(a_mask, 32'h0000_0055);
    msk = 7'h55;
    rd(a_stat, {25'h0, stat}, 1'b0);
    wr(a_mask, 32'h0000_007f);
    msk = 7'h7f;
    rd(a_mask, 32'h7f, 1'b0);
    repeat (3) @(posedge core_clk);
    check("pending notes", evq.size() + rdq.size(), 32'h0);
    give_verdict();
  end
endmodule
